/* rtl/pmr_rail_regs.sv */
// register bank for rail voltage, enable, lockout and strobe slots
`timescale 1ns/100ps
`include "pmr_params.svh"
module pmr_rail_regs #(
   parameter int MS_CYCLES = `PMR_MS_CYCLES
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // register access from the serial front end
   input  wire pmr_pkg::pmr_req_s req,
   output logic [7:0]             rdata,
   output logic                   write_refused,
   // pins and neighbouring register fields
   input  wire logic              power_enable_pin,
   input  wire logic              power_up_trigger,
   input  wire logic              power_down_trigger,
   input  wire logic              instant_shutdown_bit,
   input  wire logic [11:0]       step_delay_codes,
   input  wire logic [5:0]        buck3_voltage_code,
   input  wire logic [2:0]        switch2_strobe_slot,
   // rail controls
   output pmr_pkg::pmr_rails_s    rail_on,
   output logic                   switch1_as_regulator,
   output logic                   switch2_as_regulator,
   output logic [11:0]            reg2_millivolts,
   output logic [11:0]            reg3_millivolts,
   output logic [11:0]            reg4_millivolts,
   output logic [11:0]            lockout_millivolts,
   output logic                   sequencer_busy
);
   logic [7:0]          regs [`PMR_REG_COUNT];
   logic [7:0]          next_regs [`PMR_REG_COUNT];
   logic                armed, next_armed;
   logic [7:0]          armed_addr, next_armed_addr;
   logic [7:0]          next_rdata;
   logic                next_refused;
   logic [7:0]          diff;
   logic [3:0]          idx;
   logic                mapped, accept;
   logic [6:0][3:0]     rail_strobe;
   pmr_pkg::pmr_rails_s set_rails, clr_rails, en_bits, next_rail_on;
   logic [5:0]          reg2_code;
   logic [11:0]         next_reg2_mv, next_reg3_mv, next_reg4_mv;
   logic [11:0]         next_lock_mv;

   function automatic logic [7:0] reset_val(input int i);
      case (i)
         `PMR_IDX_REG2:    reset_val = `PMR_RST_REG2;
         `PMR_IDX_SWITCH1: reset_val = `PMR_RST_SWITCH1;
         `PMR_IDX_SWITCH2: reset_val = `PMR_RST_SWITCH2;
         default:          reset_val = `PMR_RST_ZERO;
      endcase
   endfunction : reset_val

   function automatic logic [7:0] wmask(input logic [3:0] i);
      case (i)
         4'h0:    wmask = `PMR_WM_REG2;
         4'h1:    wmask = `PMR_WM_SWITCH;
         4'h2:    wmask = `PMR_WM_SWITCH;
         4'h3:    wmask = `PMR_WM_ENABLE;
         4'h5:    wmask = `PMR_WM_LOCKOUT;
         4'h6:    wmask = `PMR_WM_SEQ_A;
         4'h7:    wmask = `PMR_WM_SEQ_B;
         4'h8:    wmask = `PMR_WM_SEQ_C;
         default: wmask = 8'h00;
      endcase
   endfunction : wmask

   // six-bit code: 25 mV, 50 mV then coarse steps, clamped at 3.3 V
   function automatic logic [11:0] v6_mv(input logic [5:0] c);
      logic [11:0] x;
      x = {6'h00, c};
      if (c < 6'h18)      v6_mv = 12'h384 + 12'h019 * x;
      else if (c < 6'h30) v6_mv = 12'h5DC + 12'h032 * (x - 12'h018);
      else if (c < 6'h35) v6_mv = 12'hA8C + 12'h032 * (x - 12'h030);
      else if (c < 6'h38) v6_mv = 12'hBB8 + 12'h064 * (x - 12'h035);
      else                v6_mv = 12'hCE4;
   endfunction : v6_mv

   // five-bit code: 1.5 V at zero up to 3.3 V at all ones
   function automatic logic [11:0] v5_mv(input logic [4:0] c);
      logic [11:0] x;
      x = {7'h00, c};
      if (c < 5'h08)       v5_mv = 12'h5DC + 12'h032 * x;
      else if (c == 5'h08) v5_mv = 12'h76C;
      else if (c < 5'h0E)  v5_mv = 12'h7D0 + 12'h064 * (x - 12'h009);
      else if (c == 5'h0E) v5_mv = 12'h992;
      else if (c == 5'h0F) v5_mv = 12'h9C4;
      else                 v5_mv = 12'h9F6 + 12'h032 * (x - 12'h010);
   endfunction : v5_mv

   // three-bit slot; only buck3 reaches strobe seven
   function automatic logic [3:0] slot3(input logic [2:0] s,
                                        input logic       seven);
      slot3 = (s == 3'h7 && !seven) ? 4'h6 : {1'b0, s};
   endfunction : slot3

   // four-bit slot of reg1 and reg2
   function automatic logic [3:0] slot4(input logic [3:0] s);
      slot4 = (s >= 4'h8 && s <= 4'hD) ? 4'h0 : s;
   endfunction : slot4

   assign diff   = req.addr - `PMR_OFF_FIRST;
   assign idx    = diff[3:0];
   assign mapped = (diff < 8'(`PMR_REG_COUNT)) && (idx != 4'(`PMR_IDX_GAP));
   assign accept = armed && (armed_addr == req.addr);

   always_comb begin
      for (int i = 0; i < `PMR_REG_COUNT; i++) begin
         next_regs[i] = regs[i];
      end
      next_armed      = armed;
      next_armed_addr = armed_addr;
      next_refused    = 1'b0;
      next_rdata      = rdata;
      if (req.wr) begin
         // any write consumes the unlock, so each write needs a fresh one
         next_armed = 1'b0;
         if (req.addr == `PMR_OFF_PASSWORD) begin
            next_armed      = 1'b1;
            next_armed_addr = req.wdata ^ `PMR_PASSWORD_KEY;
         end else if (mapped) begin
            if (accept) begin
               next_regs[idx] = (regs[idx] & ~wmask(idx))
                              | (req.wdata & wmask(idx));
            end else begin
               next_refused = 1'b1;
            end
         end
      end
      if (req.rd) begin
         next_rdata = mapped ? regs[idx] : 8'h00;
      end
      // sequencer updates win over a host write in the same cycle
      next_regs[`PMR_IDX_ENABLE] = (next_regs[`PMR_IDX_ENABLE]
                                   & ~{1'b0, clr_rails}) | {1'b0, set_rails};
   end

   always_comb begin
      rail_strobe[6] = slot3(regs[`PMR_IDX_SEQ_C][2:0], 1'b0);
      rail_strobe[5] = slot3(switch2_strobe_slot, 1'b0);
      rail_strobe[4] = slot3(regs[`PMR_IDX_SEQ_A][6:4], 1'b0);
      rail_strobe[3] = slot3(regs[`PMR_IDX_SEQ_A][2:0], 1'b0);
      rail_strobe[2] = slot3(regs[`PMR_IDX_SEQ_B][6:4], 1'b1);
      rail_strobe[1] = slot4(regs[`PMR_IDX_SEQ_B][3:0]);
      rail_strobe[0] = slot4(regs[`PMR_IDX_SEQ_C][7:4]);
   end

   pmr_sequencer #(
      .MS_CYCLES (MS_CYCLES)
   ) u_seq (
      .clk                  (clk),
      .rst_n                (rst_n),
      .power_enable_pin     (power_enable_pin),
      .power_up_trigger     (power_up_trigger),
      .power_down_trigger   (power_down_trigger),
      .instant_shutdown_bit (instant_shutdown_bit),
      .step_delay_codes     (step_delay_codes),
      .rail_strobe          (rail_strobe),
      .set_rails            (set_rails),
      .clr_rails            (clr_rails),
      .busy                 (sequencer_busy)
   );

   assign en_bits = pmr_pkg::pmr_rails_s'(regs[`PMR_IDX_ENABLE][6:0]);

   always_comb begin
      // switch and buck rails gated by the pin
      next_rail_on         = en_bits;
      next_rail_on.switch1 = en_bits.switch1 & power_enable_pin;
      next_rail_on.switch2 = en_bits.switch2 & power_enable_pin;
      next_rail_on.buck1   = en_bits.buck1 & power_enable_pin;
      next_rail_on.buck2   = en_bits.buck2 & power_enable_pin;
      next_rail_on.buck3   = en_bits.buck3 & power_enable_pin;
      reg2_code    = regs[`PMR_IDX_REG2][`PMR_TRACK_BIT] ?
                     buck3_voltage_code : regs[`PMR_IDX_REG2][5:0];
      next_reg2_mv = v6_mv(reg2_code);
      next_reg3_mv = regs[`PMR_IDX_SWITCH1][`PMR_MODE_BIT] ?
                     v5_mv(regs[`PMR_IDX_SWITCH1][4:0]) : 12'h000;
      next_reg4_mv = regs[`PMR_IDX_SWITCH2][`PMR_MODE_BIT] ?
                     v5_mv(regs[`PMR_IDX_SWITCH2][4:0]) : 12'h000;
      case (regs[`PMR_IDX_LOCKOUT][1:0])
         2'h0:    next_lock_mv = 12'hAAA;
         2'h1:    next_lock_mv = 12'hB4A;
         2'h2:    next_lock_mv = 12'hC6C;
         default: next_lock_mv = 12'hCE4;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < `PMR_REG_COUNT; i++) begin
            regs[i] <= reset_val(i);
         end
         armed                <= 1'b0;
         armed_addr           <= 8'h00;
         rdata                <= 8'h00;
         write_refused        <= 1'b0;
         rail_on              <= '0;
         switch1_as_regulator <= 1'b0;
         switch2_as_regulator <= 1'b0;
         reg2_millivolts      <= 12'h000;
         reg3_millivolts      <= 12'h000;
         reg4_millivolts      <= 12'h000;
         lockout_millivolts   <= 12'h000;
      end else begin
         for (int i = 0; i < `PMR_REG_COUNT; i++) begin
            regs[i] <= next_regs[i];
         end
         armed                <= next_armed;
         armed_addr           <= next_armed_addr;
         rdata                <= next_rdata;
         write_refused        <= next_refused;
         rail_on              <= next_rail_on;
         switch1_as_regulator <= regs[`PMR_IDX_SWITCH1][`PMR_MODE_BIT];
         switch2_as_regulator <= regs[`PMR_IDX_SWITCH2][`PMR_MODE_BIT];
         reg2_millivolts      <= next_reg2_mv;
         reg3_millivolts      <= next_reg3_mv;
         reg4_millivolts      <= next_reg4_mv;
         lockout_millivolts   <= next_lock_mv;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   locked_write_a: assert property (
      (req.wr && mapped && !accept)
      |=> write_refused && regs[`PMR_IDX_LOCKOUT] == $past(regs[`PMR_IDX_LOCKOUT]))
      else $error("write without password was not refused");
   reg2_lsb_a: assert property (
      (req.wr && accept && req.addr == `PMR_OFF_REG2)
      |=> regs[`PMR_IDX_REG2][0] == $past(regs[`PMR_IDX_REG2][0]))
      else $error("reg2 code LSB changed on write");
   reserved_read_a: assert property (
      (req.rd && req.addr == `PMR_OFF_ENABLE) |=> rdata[7] == 1'b0)
      else $error("reserved enable bit read non-zero");
   pin_gate_a: assert property (
      !power_enable_pin |=> !rail_on.switch1 && !rail_on.buck1
                            && !rail_on.buck3)
      else $error("gated rail on while power enable low");
   reg2_bit_a: assert property (
      regs[`PMR_IDX_ENABLE][0] |=> rail_on.reg2)
      else $error("reg2 enable bit not reaching the rail");
   track_low_a: assert property (
      (regs[`PMR_IDX_REG2][`PMR_TRACK_BIT] && buck3_voltage_code == 6'h00)
      |=> reg2_millivolts == 12'h384)
      else $error("tracking reg2 did not follow buck3 code");
   reg2_top_a: assert property (
      (!regs[`PMR_IDX_REG2][`PMR_TRACK_BIT]
       && regs[`PMR_IDX_REG2][5:3] == 3'h7) |=> reg2_millivolts == 12'hCE4)
      else $error("reg2 top codes not at 3.3 V");
   switch_mode_a: assert property (
      !regs[`PMR_IDX_SWITCH1][`PMR_MODE_BIT]
      |=> reg3_millivolts == 12'h000 && !switch1_as_regulator)
      else $error("reg3 voltage applied in switch mode");
   lockout_a: assert property (
      regs[`PMR_IDX_LOCKOUT][1:0] == 2'h2 |=> lockout_millivolts == 12'hC6C)
      else $error("lockout code 2 not at 3.18 V");
   buck_seven_a: assert property (
      regs[`PMR_IDX_SEQ_A][6:4] == 3'h7 |-> rail_strobe[4] == 4'h6)
      else $error("buck1 slot 7 not at strobe six");
   buck3_seven_a: assert property (
      regs[`PMR_IDX_SEQ_B][6:4] == 3'h7 |-> rail_strobe[2] == 4'h7)
      else $error("buck3 slot 7 not at strobe seven");
   reg1_free_a: assert property (
      regs[`PMR_IDX_SEQ_B][3:0] inside {[4'h8:4'hD]} |-> rail_strobe[1] == 4'h0)
      else $error("reg1 unsequenced code gave a strobe");
   reg2_fifteen_a: assert property (
      regs[`PMR_IDX_SEQ_C][7:4] == 4'hF |-> rail_strobe[0] == 4'hF)
      else $error("reg2 slot 15 not at strobe fifteen");

   accepted_write_c: cover property (req.wr && mapped && accept);
   refused_write_c: cover property (req.wr && mapped && !accept);
   tracking_c: cover property (regs[`PMR_IDX_REG2][`PMR_TRACK_BIT]);
endmodule : pmr_rail_regs

/* rtl/pmr_params.svh */
// constants of the rail configuration register bank
`ifndef PMR_PARAMS_SVH
`define PMR_PARAMS_SVH

`define PMR_CLK_HZ        20000000
`define PMR_MS_CYCLES     (`PMR_CLK_HZ / 1000)

// register offsets
`define PMR_OFF_FIRST     8'h13
`define PMR_OFF_REG2      8'h13
`define PMR_OFF_SWITCH1   8'h14
`define PMR_OFF_SWITCH2   8'h15
`define PMR_OFF_ENABLE    8'h16
`define PMR_OFF_LOCKOUT   8'h18
`define PMR_OFF_SEQ_A     8'h19
`define PMR_OFF_SEQ_B     8'h1A
`define PMR_OFF_SEQ_C     8'h1B
`define PMR_OFF_PASSWORD  8'h0A
// value is arbitrary
`define PMR_PASSWORD_KEY  8'h5A

// array indices of the bank (offset minus first offset)
`define PMR_REG_COUNT     9
`define PMR_IDX_REG2      0
`define PMR_IDX_SWITCH1   1
`define PMR_IDX_SWITCH2   2
`define PMR_IDX_ENABLE    3
`define PMR_IDX_GAP       4
`define PMR_IDX_LOCKOUT   5
`define PMR_IDX_SEQ_A     6
`define PMR_IDX_SEQ_B     7
`define PMR_IDX_SEQ_C     8

// reset values
`define PMR_RST_REG2      8'h38
`define PMR_RST_SWITCH1   8'h26
`define PMR_RST_SWITCH2   8'h3F
`define PMR_RST_ZERO      8'h00

// writable bits; reserved and fixed bits stay out of the mask
`define PMR_WM_REG2       8'h7E
`define PMR_WM_SWITCH     8'h3F
`define PMR_WM_ENABLE     8'h7F
`define PMR_WM_LOCKOUT    8'h07
`define PMR_WM_SEQ_A      8'h77
`define PMR_WM_SEQ_B      8'h7F
`define PMR_WM_SEQ_C      8'hF7

// field positions
`define PMR_TRACK_BIT     6
`define PMR_MODE_BIT      5

// strobe step delays in ms, and the last strobe number
`define PMR_DLY_MS_0      1
`define PMR_DLY_MS_1      2
`define PMR_DLY_MS_2      5
`define PMR_DLY_MS_3      10
`define PMR_STROBE_LAST   4'hF

`endif

/* rtl/pmr_pkg.sv */
// types shared by the rail configuration register bank
package pmr_pkg;

   // bit order matches the enable register, bit 6 down to bit 0
   typedef struct packed {
      logic switch1;
      logic switch2;
      logic buck1;
      logic buck2;
      logic buck3;
      logic reg1;
      logic reg2;
   } pmr_rails_s;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pmr_req_s;

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_UP,
      SEQ_DOWN
   } pmr_seq_e;

endpackage : pmr_pkg

/* rtl/pmr_sequencer.sv */
// power-up and power-down strobe sequencer
`timescale 1ns/100ps
`include "pmr_params.svh"
module pmr_sequencer #(
   parameter int MS_CYCLES = `PMR_MS_CYCLES
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // triggers
   input  wire logic              power_enable_pin,
   input  wire logic              power_up_trigger,
   input  wire logic              power_down_trigger,
   input  wire logic              instant_shutdown_bit,
   input  wire logic [11:0]       step_delay_codes,
   // strobe number of each rail, 0 = not sequenced
   input  wire logic [6:0][3:0]   rail_strobe,
   // rail enable updates
   output pmr_pkg::pmr_rails_s    set_rails,
   output pmr_pkg::pmr_rails_s    clr_rails,
   output logic                   busy
);
   pmr_pkg::pmr_seq_e   state, next_state;
   logic [3:0]          strobe, next_strobe;
   logic [23:0]         wait_cnt, next_wait_cnt;
   logic                pin_q, next_pin_q;
   pmr_pkg::pmr_rails_s next_set, next_clr, matched, seq_mask;
   logic                up_req, down_req, next_busy;

   function automatic logic [23:0] dly_cycles(input logic [1:0] code);
      case (code)
         2'h0:    dly_cycles = 24'(`PMR_DLY_MS_0 * MS_CYCLES);
         2'h1:    dly_cycles = 24'(`PMR_DLY_MS_1 * MS_CYCLES);
         2'h2:    dly_cycles = 24'(`PMR_DLY_MS_2 * MS_CYCLES);
         default: dly_cycles = 24'(`PMR_DLY_MS_3 * MS_CYCLES);
      endcase
   endfunction : dly_cycles

   // strobes past the sixth reuse the sixth delay
   function automatic logic [23:0] step_wait(input logic [3:0] s);
      logic [2:0] k;
      k = (s > 4'h6) ? 3'h5 : 3'(s - 4'h1);
      step_wait = dly_cycles(step_delay_codes[2*k +: 2]) - 24'h1;
   endfunction : step_wait

   always_comb begin
      for (int i = 0; i < 7; i++) begin
         matched[i]  = (rail_strobe[i] == strobe);
         seq_mask[i] = (rail_strobe[i] != 4'h0);
      end
   end

   assign up_req   = (power_enable_pin & ~pin_q) | power_up_trigger;
   assign down_req = (~power_enable_pin & pin_q) | power_down_trigger;

   always_comb begin
      next_state    = state;
      next_strobe   = strobe;
      next_wait_cnt = wait_cnt;
      next_pin_q    = power_enable_pin;
      next_set      = '0;
      next_clr      = '0;
      // a down request preempts any running power-up
      if (down_req) begin
         if (instant_shutdown_bit) begin
            next_clr   = seq_mask;
            next_state = pmr_pkg::SEQ_IDLE;
         end else begin
            next_state    = pmr_pkg::SEQ_DOWN;
            next_strobe   = `PMR_STROBE_LAST;
            next_wait_cnt = '0;
         end
      end else begin
         case (state)
            pmr_pkg::SEQ_IDLE: begin
               if (up_req) begin
                  next_state    = pmr_pkg::SEQ_UP;
                  next_strobe   = 4'h1;
                  next_wait_cnt = '0;
               end
            end
            pmr_pkg::SEQ_UP: begin
               if (wait_cnt == '0) begin
                  next_set      = matched;
                  next_wait_cnt = step_wait(strobe);
                  if (strobe == `PMR_STROBE_LAST) begin
                     next_state = pmr_pkg::SEQ_IDLE;
                  end else begin
                     next_strobe = strobe + 4'h1;
                  end
               end else begin
                  next_wait_cnt = wait_cnt - 24'h1;
               end
            end
            pmr_pkg::SEQ_DOWN: begin
               if (wait_cnt == '0) begin
                  next_clr      = matched;
                  next_wait_cnt = step_wait(strobe);
                  if (strobe == 4'h1) begin
                     next_state = pmr_pkg::SEQ_IDLE;
                  end else begin
                     next_strobe = strobe - 4'h1;
                  end
               end else begin
                  next_wait_cnt = wait_cnt - 24'h1;
               end
            end
            default: next_state = pmr_pkg::SEQ_IDLE;
         endcase
      end
      next_busy = (next_state != pmr_pkg::SEQ_IDLE);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state     <= pmr_pkg::SEQ_IDLE;
         strobe    <= 4'h0;
         wait_cnt  <= 24'h0;
         pin_q     <= 1'b0;
         set_rails <= '0;
         clr_rails <= '0;
         busy      <= 1'b0;
      end else begin
         state     <= next_state;
         strobe    <= next_strobe;
         wait_cnt  <= next_wait_cnt;
         pin_q     <= next_pin_q;
         set_rails <= next_set;
         clr_rails <= next_clr;
         busy      <= next_busy;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   up_ascend_a: assert property (
      (state == pmr_pkg::SEQ_UP && $past(state) == pmr_pkg::SEQ_UP
       && $changed(strobe)) |-> strobe == $past(strobe) + 4'h1)
      else $error("power-up strobe did not step by one");
   step_wait_a: assert property (
      (state != pmr_pkg::SEQ_IDLE && $past(state) == state
       && $changed(strobe)) |-> $past(wait_cnt) == 24'h0)
      else $error("strobe advanced before its delay ran out");
   first_delay_a: assert property (
      (state == pmr_pkg::SEQ_UP && wait_cnt == 24'h0 && strobe == 4'h1
       && !down_req && step_delay_codes[1:0] == 2'h3)
      |=> wait_cnt == 24'(`PMR_DLY_MS_3 * MS_CYCLES - 1))
      else $error("delay code 3 did not load ten ms");
   instant_down_a: assert property (
      (down_req && instant_shutdown_bit)
      |=> clr_rails == $past(seq_mask) && state == pmr_pkg::SEQ_IDLE)
      else $error("instant shutdown did not clear all sequenced rails");
   down_no_set_a: assert property (
      state == pmr_pkg::SEQ_DOWN |=> set_rails == '0)
      else $error("rail enabled during power-down");

   up_done_c: cover property (
      state == pmr_pkg::SEQ_UP && strobe == 4'hF && wait_cnt == 24'h0);
   rev_down_c: cover property (
      state == pmr_pkg::SEQ_DOWN && strobe == 4'h1 && wait_cnt == 24'h0);
endmodule : pmr_sequencer

/* bench/pmr_host.sv */
// host model driving register requests into the bank
`timescale 1ns/100ps
`include "pmr_params.svh"
module pmr_host (
   // clock
   input  wire logic         clk,
   // request to the register bank
   output pmr_pkg::pmr_req_s req
);
   initial req = '0;
   // held requests chain back to back, one per cycle
   task xfer(input logic w, input logic r, input logic [7:0] a,
             input logic [7:0] d);
      @(posedge clk);
      #1 req <= {w, r, a, d};
   endtask : xfer
   // released lines show the inverse of their last value
   task idle();
      @(posedge clk);
      #1 req <= {2'b00, ~req.addr, ~req.wdata};
   endtask : idle
   task write(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, 1'b0, `PMR_OFF_PASSWORD, a ^ `PMR_PASSWORD_KEY);
      xfer(1'b1, 1'b0, a, d);
   endtask : write
endmodule : pmr_host

/* bench/tb.sv */
// self-checking bench for the rail configuration register bank
`timescale 1ns/100ps
module tb;
   typedef struct {int sel; logic [11:0] val;} pmr_note_s;
   logic                clk = 0, rst_n = 0, pin = 0, up = 0;
   logic                pr = 0, rd_q = 0, pr_q = 0, dn = 0;
   logic [5:0]          b3 = '0;
   logic [7:0]          rdata;
   logic [11:0]         mv2, mv3, lk, got;
   pmr_pkg::pmr_req_s   req;
   pmr_pkg::pmr_rails_s rail_on;
   pmr_note_s           n, notes[$];
   int                  error_cnt = 0, n_checks = 0, seed = 96620;
   always #25 clk = ~clk;
   pmr_host i_pmr_host (.clk(clk), .req(req));
   pmr_rail_regs #(.MS_CYCLES(4)) i_pmr_rail_regs (.clk(clk),
      .rst_n(rst_n), .req(req), .rdata(rdata), .write_refused(),
      .power_enable_pin(pin), .power_up_trigger(up),
      .power_down_trigger(dn), .instant_shutdown_bit(1'b0),
      .step_delay_codes(12'h000), .buck3_voltage_code(b3),
      .switch2_strobe_slot(3'h0), .rail_on(rail_on),
      .switch1_as_regulator(), .switch2_as_regulator(),
      .reg2_millivolts(mv2), .reg3_millivolts(mv3),
      .reg4_millivolts(), .lockout_millivolts(lk), .sequencer_busy());
   always @(posedge clk) begin
      if (rd_q || pr_q) begin
         n = notes.pop_front();
         case (n.sel)
            0: got = {4'h0, rdata};
            1: got = mv2;
            2: got = mv3;
            3: got = lk;
            default: got = {5'h00, rail_on};
         endcase
         n_checks++;
         if (got !== n.val) begin
            error_cnt++;
            $display("CHECK FAILED %0t sel %0d got %h exp %h", $time,
                     n.sel, got, n.val);
         end
      end
      rd_q <= req.rd;
      pr_q <= pr;
   end
   function automatic logic [11:0] mv_a(input logic [5:0] c);
      if (c < 6'h18) return 12'h384 + 12'h019 * c;
      if (c < 6'h30) return 12'h5DC + 12'h032 * (c - 6'h18);
      if (c < 6'h35) return 12'hA8C + 12'h032 * (c - 6'h30);
      if (c < 6'h38) return 12'hBB8 + 12'h064 * (c - 6'h35);
      return 12'hCE4;
   endfunction : mv_a
   function automatic logic [11:0] mv_b(input logic [4:0] c);
      if (c < 5'h09) return 12'h5DC + 12'h032 * c;
      if (c < 5'h0E) return 12'h7D0 + 12'h064 * (c - 5'h09);
      if (c < 5'h10) return 12'h992 + 12'h032 * (c - 5'h0E);
      return 12'h9F6 + 12'h032 * (c - 5'h10);
   endfunction : mv_b
   task rd(input logic [7:0] a, input logic [7:0] v);
      notes.push_back('{0, {4'h0, v}});
      i_pmr_host.xfer(1'b0, 1'b1, a, 8'h00);
   endtask : rd
   // settled outputs are sampled once the write has landed
   task probe(input int s, input logic [11:0] v);
      i_pmr_host.idle();
      repeat (3) @(posedge clk);
      notes.push_back('{s, v});
      #1 pr = 1;
      @(posedge clk);
      #1 pr = 0;
   endtask : probe
   task results();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results
   initial begin
      int         i;
      logic [5:0] c;
      logic [7:0] rv [9] = '{8'h38, 8'h26, 8'h3F, 0, 0, 0, 0, 0, 0};
      logic [7:0] wv [9] = '{8'h7E, 8'h3F, 8'h3F, 8'h7F, 8'h00, 8'h07,
                             8'h77, 8'h7F, 8'hF7};
      logic [11:0] lv [4] = '{12'hAAA, 12'hB4A, 12'hC6C, 12'hCE4};
      repeat (2) @(posedge clk);
      #1 rst_n = 1;
      for (i = 0; i < 9; i++) rd(8'h13 + i[7:0], rv[i]);
      probe(2, mv_b(5'h06));
      i_pmr_host.xfer(1'b1, 1'b0, 8'h16, 8'h7F);
      rd(8'h16, 8'h00);
      for (i = 0; i < 9; i++) begin
         i_pmr_host.write(8'h13 + i[7:0], 8'hFF);
         rd(8'h13 + i[7:0], wv[i]);
      end
      $display("done: reset values and masks");
      for (i = 0; i < 4; i++) begin
         b3 = 6'($random(seed));
         probe(1, mv_a(b3));
      end
      for (i = 0; i < 6; i++) begin
         c = 6'($random(seed));
         i_pmr_host.write(8'h13, {2'b00, c});
         probe(1, mv_a({c[5:1], 1'b0}));
         i_pmr_host.write(8'h14, {2'b00, c});
         probe(2, c[5] ? mv_b(c[4:0]) : 12'h000);
      end
      for (i = 0; i < 4; i++) begin
         i_pmr_host.write(8'h18, 8'(i));
         probe(3, lv[i]);
      end
      $display("done: voltage codes");
      i_pmr_host.write(8'h16, 8'h7F);
      probe(4, 12'h003);
      pin = 1;
      probe(4, 12'h07F);
      // the pin edge started a power-up; let it finish before the next
      repeat (60) @(posedge clk);
      i_pmr_host.write(8'h16, 8'h00);
      i_pmr_host.write(8'h19, 8'h10);
      i_pmr_host.idle();
      #1 up = 1;
      @(posedge clk);
      #1 up = 0;
      repeat (2) @(posedge clk);
      rd(8'h16, 8'h10);
      i_pmr_host.idle();
      repeat (80) @(posedge clk);
      rd(8'h16, 8'h57);
      i_pmr_host.idle();
      #1 dn = 1;
      @(posedge clk);
      #1 dn = 0;
      repeat (70) @(posedge clk);
      rd(8'h16, 8'h00);
      i_pmr_host.idle();
      repeat (4) @(posedge clk);
      $display("done: enables and sequencing");
      results();
   end
   initial begin
      #2000000;
      error_cnt++;
      results();
   end
endmodule : tb
